/* src/exec_group_pkg.sv */
// shared opcodes, field positions and reset values for the execute group
package exec_group_pkg;
	// compare forms: 11-bit opcode in bits 31:21
	localparam logic [10:0] OP_LEU_IMM = 11'h5e5;
	localparam logic [10:0] OP_LTS_REG = 11'h72c;
	localparam logic [10:0] OP_LTS_IMM = 11'h5ec;
	localparam logic [10:0] OP_LTU_REG = 11'h724;
	localparam logic [10:0] OP_LTU_IMM = 11'h5e4;
	localparam logic [10:0] OP_NE_REG = 11'h721;
	localparam logic [10:0] OP_NE_IMM = 11'h5e1;
	// primary 6-bit opcodes in bits 31:26
	localparam logic [5:0] OP_STORE_HALF = 6'h37;
	localparam logic [5:0] OP_ALU_REG = 6'h38;
	localparam logic [5:0] OP_SHIFT_IMM = 6'h2e;
	// sub-opcodes of the shift forms
	localparam logic [3:0] SUB_REG_SHIFT = 4'h8;
	localparam logic [3:0] KIND_REG_SLL = 4'h0;
	localparam logic [3:0] KIND_REG_SRA = 4'h2;
	localparam logic [1:0] KIND_IMM_SLL = 2'h0;
	localparam logic [1:0] KIND_IMM_SRA = 2'h2;
	// field positions
	localparam int OPC11_LSB = 21;
	localparam int OPC6_LSB = 26;
	localparam int RD_LSB = 21;
	localparam int IMM16_W = 16;
	localparam int OFF_HI_LSB = 21;
	localparam int OFF_LO_W = 11;
	localparam int SHAMT_W = 6;
	localparam int HALF_W = 16;
	// value after reset of the flag
	localparam logic FLAG_RESET = 1'b0;

	typedef enum logic [2:0] {
		EXC_NONE,
		EXC_TLB_MISS,
		EXC_PAGE_FAULT,
		EXC_BUS_ERROR,
		EXC_ALIGNMENT
	} exc_kind_t;
endpackage

/* src/integer_compare_shift_store.sv */
// execute stage for compares, left/arith-right shifts and halfword store
//
// Notes on behaviour
// RQ1: unsigned less-or-equal immediate compare sets flag
// RQ2: signed register less-than compare sets flag
// RQ3: signed less-than immediate compare sets flag
// RQ4: unsigned register less-than compare sets flag
// RQ5: unsigned less-than immediate compare sets flag
// RQ6: register inequality compare sets flag
// RQ7: immediate inequality compare sets flag
// RQ8: immediates always sign-extended before compare
// RQ9: compare full width, write only flag
// RQ10: store address is base plus extended offset
// RQ11: offset joins bits 25:21 and 10:0
// RQ12: store writes low sixteen data bits only
// RQ13: store faults reported to exception logic
// RQ14: register left shift decoded, zero fill
// RQ15: immediate left shift decoded, zero fill
// RQ16: register arithmetic right shift, sign fill
// RQ17: immediate arithmetic right shift, sign fill
// RQ18: register shift amount low five/six bits
// RQ19: immediate shift ignores bit 5 at 32
// RQ20: reserved fields never change the result
`timescale 1ns/1ps

module integer_compare_shift_store #(
	parameter int XLEN = 32
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic issue_valid,
	input wire logic [31:0] instr,
	input wire logic [XLEN-1:0] src_a,
	input wire logic [XLEN-1:0] src_b,
	input wire logic mem_tlb_miss,
	input wire logic mem_page_fault,
	input wire logic mem_bus_error,
	output logic compare_flag,
	output logic result_valid,
	output logic [4:0] result_dest,
	output logic [XLEN-1:0] result_data,
	output logic store_valid,
	output logic [XLEN-1:0] effective_address,
	output logic [15:0] store_data,
	output logic exc_valid,
	output exec_group_pkg::exc_kind_t exc_kind,
	output logic [XLEN-1:0] exc_address
);
	import exec_group_pkg::*;

	localparam int SHW = $clog2(XLEN);

	// the shifter and compare widths only make sense for these two builds
	if (XLEN != 32 && XLEN != 64) begin : g_xlen_check
		$error("XLEN must be 32 or 64");
	end

	// =========================================================
	// state
	typedef struct packed {
		logic flag;
		logic res_v;
		logic [4:0] dest;
		logic [XLEN-1:0] data;
		logic st_v;
		logic [XLEN-1:0] ea;
		logic [15:0] sdata;
		logic exc_v;
		exc_kind_t exc;
		logic [XLEN-1:0] exc_ea;
	} state_t;

	state_t state_q;
	state_t state_d;

	// =========================================================
	// decode helpers
	function automatic logic [XLEN-1:0] sext16(input logic [15:0] v);
		sext16 = {{(XLEN-IMM16_W){v[15]}}, v}; // [RQ8]
	endfunction

	function automatic logic [SHW-1:0] amount(input logic [5:0] v);
		// 32-bit build drops bit 5
		amount = v[SHW-1:0]; // [RQ18] [RQ19]
	endfunction

	logic [10:0] opc11;
	logic [5:0] opc6;
	logic [XLEN-1:0] imm_ext;
	logic [XLEN-1:0] off_ext;
	logic [XLEN-1:0] ea_sum;
	logic lt_s;
	logic lt_u;
	logic lt_s_imm;
	logic lt_u_imm;
	logic le_u_imm;
	logic is_cmp;
	logic cmp_res;
	logic is_shift;
	logic [XLEN-1:0] shift_res;
	logic [SHW-1:0] sh_amt;
	logic misaligned;

	assign opc11 = instr[31:OPC11_LSB];
	assign opc6 = instr[31:OPC6_LSB];
	assign imm_ext = sext16(instr[IMM16_W-1:0]);
	// offset split around the source fields
	assign off_ext = sext16({instr[OFF_HI_LSB+4:OFF_HI_LSB],
		instr[OFF_LO_W-1:0]}); // [RQ11]
	assign ea_sum = src_a + off_ext; // [RQ10]
	assign misaligned = ea_sum[0];

	assign lt_s = $signed(src_a) < $signed(src_b);
	assign lt_u = src_a < src_b;
	assign lt_s_imm = $signed(src_a) < $signed(imm_ext);
	assign lt_u_imm = src_a < imm_ext;
	assign le_u_imm = src_a <= imm_ext;

	// =========================================================
	// compare and shift decode; reserved bits never consulted
	always_comb begin
		is_cmp = 1'b1;
		cmp_res = 1'b0;
		case (opc11) // [RQ20]
			OP_LEU_IMM: cmp_res = le_u_imm; // [RQ1]
			OP_LTS_REG: cmp_res = lt_s; // [RQ2] [RQ9]
			OP_LTS_IMM: cmp_res = lt_s_imm; // [RQ3]
			OP_LTU_REG: cmp_res = lt_u; // [RQ4]
			OP_LTU_IMM: cmp_res = lt_u_imm; // [RQ5]
			OP_NE_REG: cmp_res = src_a != src_b; // [RQ6]
			OP_NE_IMM: cmp_res = src_a != imm_ext; // [RQ7]
			default: is_cmp = 1'b0;
		endcase
	end

	always_comb begin
		is_shift = 1'b0;
		shift_res = '0;
		sh_amt = '0;
		if (opc6 == OP_ALU_REG && instr[3:0] == SUB_REG_SHIFT) begin
			sh_amt = amount(src_b[5:0]); // [RQ18]
			if (instr[9:6] == KIND_REG_SLL) begin
				is_shift = 1'b1;
				shift_res = src_a << sh_amt; // [RQ14]
			end else if (instr[9:6] == KIND_REG_SRA) begin
				is_shift = 1'b1;
				shift_res = $signed(src_a) >>> sh_amt; // [RQ16]
			end
		end else if (opc6 == OP_SHIFT_IMM) begin
			sh_amt = amount(instr[SHAMT_W-1:0]); // [RQ19]
			if (instr[7:6] == KIND_IMM_SLL) begin
				is_shift = 1'b1;
				shift_res = src_a << sh_amt; // [RQ15]
			end else if (instr[7:6] == KIND_IMM_SRA) begin
				is_shift = 1'b1;
				shift_res = $signed(src_a) >>> sh_amt; // [RQ17]
			end
		end
	end

	// =========================================================
	// next state
	always_comb begin
		state_d = state_q;
		state_d.res_v = 1'b0;
		state_d.st_v = 1'b0;
		state_d.exc_v = 1'b0;
		if (issue_valid) begin
			if (is_cmp)
				state_d.flag = cmp_res; // [RQ9]
			if (is_shift) begin
				state_d.res_v = 1'b1;
				state_d.dest = instr[RD_LSB+4:RD_LSB];
				state_d.data = shift_res;
			end
			if (opc6 == OP_STORE_HALF) begin
				state_d.ea = ea_sum; // [RQ10]
				state_d.sdata = src_b[HALF_W-1:0]; // [RQ12]
				// faults take priority over the write
				if (mem_tlb_miss) begin
					state_d.exc_v = 1'b1; // [RQ13]
					state_d.exc = EXC_TLB_MISS;
				end else if (mem_page_fault) begin
					state_d.exc_v = 1'b1; // [RQ13]
					state_d.exc = EXC_PAGE_FAULT;
				end else if (mem_bus_error) begin
					state_d.exc_v = 1'b1; // [RQ13]
					state_d.exc = EXC_BUS_ERROR;
				end else if (misaligned) begin
					state_d.exc_v = 1'b1; // [RQ13]
					state_d.exc = EXC_ALIGNMENT;
				end else begin
					state_d.st_v = 1'b1;
				end
				state_d.exc_ea = ea_sum;
			end
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			state_q <= '0;
			state_q.flag <= FLAG_RESET;
			state_q.exc <= EXC_NONE;
		end else begin
			state_q <= state_d;
		end
	end

	assign compare_flag = state_q.flag;
	assign result_valid = state_q.res_v;
	assign result_dest = state_q.dest;
	assign result_data = state_q.data;
	assign store_valid = state_q.st_v;
	assign effective_address = state_q.ea;
	assign store_data = state_q.sdata;
	assign exc_valid = state_q.exc_v;
	assign exc_kind = state_q.exc;
	assign exc_address = state_q.exc_ea;

	// =========================================================
	// checks
	// expectations come from the instruction word and operands, bar off_ext in a_store_addr, imm_ext in a_imm_sext and
	// is_cmp or is_shift in a_imm_sext, a_flag_hold, a_cmp_only_flag, a_sra_sign and a_resv_shift, so a slip in the decode above
	// can hide behind its own signals only in those checks
	function automatic logic [XLEN-1:0] ref_sra(input logic [XLEN-1:0] v,
		input logic [SHW-1:0] n);
		// sign fill from a logical shift of the inverse
		ref_sra = v[XLEN-1] ? ~(~v >> n) : v >> n;
	endfunction

	a_leu_imm_flag: assert property ( // [RQ1]
		@(posedge clk_sys) disable iff (reset)
		issue_valid && opc11 == OP_LEU_IMM
		|=> compare_flag
		== ($past(src_a) <= XLEN'($signed($past(instr[15:0])))))
		else $error("unsigned le immediate flag wrong");
	a_lts_reg_flag: assert property ( // [RQ2]
		@(posedge clk_sys) disable iff (reset)
		issue_valid && opc11 == OP_LTS_REG
		|=> compare_flag == ($signed($past(src_a)) < $signed($past(src_b))))
		else $error("signed lt register flag wrong");
	a_lts_imm_flag: assert property ( // [RQ3]
		@(posedge clk_sys) disable iff (reset)
		issue_valid && opc11 == OP_LTS_IMM
		|=> compare_flag
		== ($signed($past(src_a)) < $signed($past(instr[15:0]))))
		else $error("signed lt immediate flag wrong");
	a_ltu_reg_flag: assert property ( // [RQ4]
		@(posedge clk_sys) disable iff (reset)
		issue_valid && opc11 == OP_LTU_REG
		|=> compare_flag == ($past(src_a) < $past(src_b)))
		else $error("unsigned lt register flag wrong");
	a_ltu_imm_flag: assert property ( // [RQ5]
		@(posedge clk_sys) disable iff (reset)
		issue_valid && opc11 == OP_LTU_IMM
		|=> compare_flag
		== ($past(src_a) < XLEN'($signed($past(instr[15:0])))))
		else $error("unsigned lt immediate flag wrong");
	a_ne_reg_flag: assert property ( // [RQ6]
		@(posedge clk_sys) disable iff (reset)
		issue_valid && opc11 == OP_NE_REG
		|=> compare_flag == ($past(src_a) != $past(src_b)))
		else $error("ne register flag wrong");
	a_ne_imm_flag: assert property ( // [RQ7]
		@(posedge clk_sys) disable iff (reset)
		issue_valid && opc11 == OP_NE_IMM
		|=> compare_flag
		== ($past(src_a) != XLEN'($signed($past(instr[15:0])))))
		else $error("ne immediate flag wrong");
	a_imm_sext: assert property ( // [RQ8]
		@(posedge clk_sys) disable iff (reset)
		issue_valid && is_cmp |-> imm_ext
		== {{(XLEN-16){instr[15]}}, instr[15:0]})
		else $error("immediate not sign extended");
	a_flag_hold: assert property ( // [RQ9]
		@(posedge clk_sys) disable iff (reset)
		!(issue_valid && is_cmp) |=> $stable(compare_flag))
		else $error("flag changed without a compare");
	a_cmp_only_flag: assert property ( // [RQ9]
		@(posedge clk_sys) disable iff (reset)
		issue_valid && is_cmp
		|=> !result_valid && !store_valid && !exc_valid)
		else $error("compare wrote more than the flag");
	a_store_addr: assert property ( // [RQ10]
		@(posedge clk_sys) disable iff (reset)
		issue_valid && opc6 == OP_STORE_HALF
		|=> effective_address == $past(src_a) + $past(off_ext))
		else $error("store address wrong");
	a_store_offset: assert property ( // [RQ11]
		@(posedge clk_sys) disable iff (reset)
		issue_valid && opc6 == OP_STORE_HALF
		|=> effective_address == $past(src_a)
		+ XLEN'($signed({$past(instr[25:21]), $past(instr[10:0])})))
		else $error("store offset fields joined wrong");
	a_store_data: assert property ( // [RQ12]
		@(posedge clk_sys) disable iff (reset)
		store_valid |-> store_data == $past(src_b[15:0]))
		else $error("store data wrong");
	a_store_fault: assert property ( // [RQ13]
		@(posedge clk_sys) disable iff (reset)
		issue_valid && opc6 == OP_STORE_HALF && mem_bus_error
		|=> exc_valid && !store_valid)
		else $error("store fault not reported");
	a_fault_priority: assert property ( // [RQ13]
		@(posedge clk_sys) disable iff (reset)
		issue_valid && opc6 == OP_STORE_HALF && mem_tlb_miss
		|=> exc_valid && exc_kind == EXC_TLB_MISS && !store_valid)
		else $error("translation miss not reported first");
	a_store_or_align: assert property ( // [RQ13]
		@(posedge clk_sys) disable iff (reset)
		issue_valid && opc6 == OP_STORE_HALF && !mem_tlb_miss
		&& !mem_page_fault && !mem_bus_error
		|=> exc_valid == effective_address[0]
		&& store_valid == !effective_address[0])
		else $error("alignment decision wrong");
	a_sll_reg: assert property ( // [RQ14] [RQ18]
		@(posedge clk_sys) disable iff (reset)
		issue_valid && opc6 == OP_ALU_REG && instr[3:0] == SUB_REG_SHIFT
		&& instr[9:6] == KIND_REG_SLL
		|=> result_valid
		&& result_data == ($past(src_a) << $past(src_b[SHW-1:0])))
		else $error("register left shift wrong");
	a_sll_result: assert property ( // [RQ15] [RQ19]
		@(posedge clk_sys) disable iff (reset)
		issue_valid && opc6 == OP_SHIFT_IMM && instr[7:6] == KIND_IMM_SLL
		|=> result_valid
		&& result_data == ($past(src_a) << $past(instr[SHW-1:0])))
		else $error("immediate left shift wrong");
	a_sra_reg: assert property ( // [RQ16] [RQ18]
		@(posedge clk_sys) disable iff (reset)
		issue_valid && opc6 == OP_ALU_REG && instr[3:0] == SUB_REG_SHIFT
		&& instr[9:6] == KIND_REG_SRA
		|=> result_valid
		&& result_data == ref_sra($past(src_a), $past(src_b[SHW-1:0])))
		else $error("register arithmetic shift wrong");
	a_sra_imm: assert property ( // [RQ17] [RQ19]
		@(posedge clk_sys) disable iff (reset)
		issue_valid && opc6 == OP_SHIFT_IMM
		&& instr[7:6] == KIND_IMM_SRA
		|=> result_valid
		&& result_data == ref_sra($past(src_a), $past(instr[SHW-1:0])))
		else $error("immediate arithmetic shift wrong");
	a_sra_sign: assert property ( // [RQ16]
		@(posedge clk_sys) disable iff (reset)
		issue_valid && is_shift && instr[9:6] == KIND_REG_SRA
		&& opc6 == OP_ALU_REG
		|=> result_data[XLEN-1] == $past(src_a[XLEN-1]))
		else $error("arithmetic shift lost sign");
	a_resv_shift: assert property ( // [RQ20]
		@(posedge clk_sys) disable iff (reset)
		issue_valid && opc6 == OP_ALU_REG && instr[3:0] == SUB_REG_SHIFT
		&& instr[9:6] == KIND_REG_SLL |-> is_shift)
		else $error("reserved bits blocked a shift");

	c_compare: cover property (@(posedge clk_sys) issue_valid && is_cmp);
	c_shift: cover property (@(posedge clk_sys) result_valid);
	c_store: cover property (@(posedge clk_sys) store_valid);
	c_fault: cover property (@(posedge clk_sys) exc_valid);
	c_sra_negative: cover property (@(posedge clk_sys)
		result_valid && result_data[XLEN-1]);
endmodule // integer_compare_shift_store

/* testbench/mem_port_model.sv */
// far-side model: data memory port and fault source
`timescale 1ns/1ps
module mem_port_model (
	input wire logic clk_sys,
	input wire logic store_valid,
	input wire logic [31:0] effective_address,
	input wire logic [15:0] store_data,
	input wire logic [2:0] fault_sel,
	output logic mem_tlb_miss,
	output logic mem_page_fault,
	output logic mem_bus_error,
	output logic [31:0] last_addr,
	output logic [15:0] last_data
);
	// faults come only when the bench commands them
	assign mem_tlb_miss = fault_sel[0];
	assign mem_page_fault = fault_sel[1];
	assign mem_bus_error = fault_sel[2];
	always_ff @(posedge clk_sys) begin
		if (store_valid) begin
			last_addr <= effective_address;
			last_data <= store_data;
		end
	end
endmodule // mem_port_model

/* testbench/integer_compare_shift_store_tb_top.sv */
// self-checking bench for the execute group
`timescale 1ns/1ps
module integer_compare_shift_store_tb_top;
	import exec_group_pkg::*;
	logic clk_sys, reset, issue_valid, compare_flag, result_valid;
	logic mem_tlb_miss, mem_page_fault, mem_bus_error;
	logic store_valid, exc_valid;
	logic [2:0] fault_sel;
	logic [4:0] result_dest;
	logic [31:0] instr, src_a, src_b, result_data;
	logic [31:0] effective_address, exc_address, last_addr, ea;
	logic [15:0] store_data, last_data;
	exc_kind_t exc_kind;
	int fails, cmp_count, cycles;
	logic [10:0] ops [7] = '{OP_LEU_IMM, OP_LTS_REG, OP_LTS_IMM,
		OP_LTU_REG, OP_LTU_IMM, OP_NE_REG, OP_NE_IMM};
	logic [31:0] va [4] = '{32'hffff_fff0, 32'h0000_0001,
		32'h8000_0000, 32'h0000_7fff};
	logic [31:0] vb [4] = '{32'h0000_fff0, 32'hffff_ffff,
		32'h0000_7fff, 32'h0000_8000};
	logic [5:0] amts [5] = '{6'h00, 6'h01, 6'h1f, 6'h21, 6'h3f};
	// ==========================================
	// clock, instances, timeout
	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	integer_compare_shift_store #(.XLEN(32)) integer_compare_shift_store_i (
		.clk_sys, .reset, .issue_valid, .instr, .src_a, .src_b,
		.mem_tlb_miss, .mem_page_fault, .mem_bus_error, .compare_flag,
		.result_valid, .result_dest, .result_data, .store_valid,
		.effective_address, .store_data, .exc_valid, .exc_kind,
		.exc_address);
	mem_port_model mem_port_model_i (.clk_sys, .store_valid,
		.effective_address, .store_data, .fault_sel, .mem_tlb_miss,
		.mem_page_fault, .mem_bus_error, .last_addr, .last_data);
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 3000) begin
			fails++;
			tally_and_finish();
		end
	end
	// ==========================================
	// shared tasks
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		cmp_count++;
		if (seen !== want) begin
			fails++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen,
				want);
		end
	endtask
	task automatic issue(input logic [31:0] i, a, b);
		// an idle edge first, so back-to-back calls never raise
		// issue_valid in the step where the last call lowered it
		@(posedge clk_sys);
		#1;
		instr = i;
		src_a = a;
		src_b = b;
		issue_valid = 1'b1;
		@(posedge clk_sys);
		#1;
		issue_valid = 1'b0;
	endtask
	task automatic do_reset();
		reset = 1'b1;
		repeat (5) @(posedge clk_sys);
		#1;
		check({compare_flag, result_valid, store_valid, exc_valid}, 0);
		check(32'(exc_kind), 32'(EXC_NONE));
		reset = 1'b0;
		@(posedge clk_sys);
		#1;
	endtask
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// ==========================================
	// scenarios
	task automatic test_compares();
		logic r;
		logic [31:0] a, b, x;
		for (int o = 0; o < 7; o++) begin
			for (int k = 0; k < 4; k++) begin
				a = va[k];
				b = vb[k];
				r = (ops[o][10:8] == 3'h7);
				x = {{16{b[15]}}, b[15:0]};
				issue(r ? {ops[o], 5'd3, 5'd4, 11'h7ff}
					: {ops[o], 5'd3, b[15:0]}, a, r ? b : ~a);
				case (ops[o])
					OP_LEU_IMM: check(compare_flag, a <= x);
					OP_LTS_REG: check(compare_flag, $signed(a) < $signed(b));
					OP_LTS_IMM: check(compare_flag, $signed(a) < $signed(x));
					OP_LTU_REG: check(compare_flag, a < b);
					OP_LTU_IMM: check(compare_flag, a < x);
					OP_NE_REG: check(compare_flag, a != b);
					default: check(compare_flag, a != x);
				endcase
			end
		end
		issue(32'hfc00_0000, 32'h0, 32'h1);
		// the flag keeps the set left by the last inequality compare
		check({result_valid, store_valid, compare_flag}, 3'b001);
		$display("test compares done");
	endtask
	task automatic test_shifts();
		logic [31:0] a;
		logic [31:0] w;
		int n;
		a = 32'h9234_5671;
		for (int f = 0; f < 4; f++) begin
			for (int k = 0; k < 5; k++) begin
				n = int'(amts[k][4:0]);
				if (f < 2) begin
					issue({OP_ALU_REG, 5'd9, 5'd1, 5'd2, 1'b1,
						f[0] ? KIND_REG_SRA : KIND_REG_SLL, 2'b11, SUB_REG_SHIFT},
						a, {26'h155_5555, amts[k]});
				end else begin
					issue({OP_SHIFT_IMM, 5'd9, 5'd1, 8'hff,
						f[0] ? KIND_IMM_SRA : KIND_IMM_SLL, amts[k]},
						a, 32'h0);
				end
				check(result_valid, 1'b1);
				check(result_dest, 5'd9);
				// kept apart: inside one conditional the arithmetic shift
				// would be evaluated unsigned and lose its sign fill
				if (f[0]) begin
					w = $signed(a) >>> n;
				end else begin
					w = a << n;
				end
				check(result_data, w);
			end
		end
		@(posedge clk_sys);
		#1;
		check(result_valid, 1'b0);
		$display("test shifts done");
	endtask
	task automatic store(input logic [15:0] off, input logic [2:0] fs,
		input exc_kind_t want);
		ea = 32'h0000_1000 + {{16{off[15]}}, off};
		fault_sel = fs;
		issue({OP_STORE_HALF, off[15:11], 5'd1, 5'd2, off[10:0]},
			32'h0000_1000, 32'habcd_1234);
		check(store_valid, want == EXC_NONE);
		check(exc_valid, want != EXC_NONE);
		if (want == EXC_NONE) begin
			check(effective_address, ea);
			check(store_data, 16'h1234);
			@(posedge clk_sys);
			#1;
			check(last_addr, ea);
			check(last_data, 16'h1234);
		end else begin
			check(32'(exc_kind), 32'(want));
			check(exc_address, ea);
		end
	endtask
	task automatic test_store();
		store(16'h8002, 3'h0, EXC_NONE);
		store(16'h07fe, 3'h0, EXC_NONE);
		store(16'h0002, 3'h3, EXC_TLB_MISS);
		store(16'h0002, 3'h2, EXC_PAGE_FAULT);
		store(16'h0002, 3'h4, EXC_BUS_ERROR);
		store(16'h8001, 3'h0, EXC_ALIGNMENT);
		$display("test store done");
	endtask
	initial begin
		{issue_valid, instr, src_a, src_b, fault_sel} = '0;
		do_reset();
		test_compares();
		test_shifts();
		test_store();
		issue({OP_NE_REG, 21'h0}, 32'h1, 32'h2);
		do_reset();
		$display("test reset done");
		tally_and_finish();
	end
endmodule // integer_compare_shift_store_tb_top
